// *** core/wrx_pkg.sv ***
// Shared constants and types for the receiver packet signalling block.
package wrx_pkg;
    // Core clock rate and the modulation bit clock, each in hertz.
    localparam int CLK_HZ        = 100_000_000;
    localparam int BIT_CLK_HZ    = 2_000;
    // Core cycles per modulated bit, derived from the two rates.
    localparam int BIT_CYCLES    = CLK_HZ / BIT_CLK_HZ;
    // Serial character layout: start, data, parity and stop bits.
    localparam int CHAR_BITS     = 11;
    localparam int DATA_BITS     = 8;
    // Optional configuration packets allowed in the configuration phase.
    localparam int MAX_OPT_CFG   = 7;
    // Preamble length in bits, all ones.
    localparam int PREAMBLE_BITS = 11;
    // Message byte buffer depth and message length field width.
    localparam int FIFO_DEPTH    = 8;
    localparam int LEN_W         = 5;
    // Default header codes that classify packets.
    localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01;
    localparam logic [7:0] HDR_END_POWER    = 8'h02;
    localparam logic [7:0] HDR_IDENT        = 8'h71;
    localparam logic [7:0] HDR_EXT_IDENT    = 8'h81;
    localparam logic [7:0] HDR_CONFIG       = 8'h51;
    // Values after reset.
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [2:0] RST_OPT_CNT      = 3'h0;

    // Link phases, stepped in order.
    typedef enum logic [1:0] {
        PH_SELECT = 2'b00,
        PH_PING   = 2'b01,
        PH_IDCFG  = 2'b10,
        PH_POWER  = 2'b11
    } wrx_phase_type;

    // Frame sequencer states.
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_PRE   = 3'b001,
        TX_CHAR  = 3'b010,
        TX_FETCH = 3'b011,
        TX_DROP  = 3'b100
    } wrx_tx_type;
endpackage

// *** core/wrx_fifo.sv ***
// Message byte buffer between the packet source and the frame sequencer.
`timescale 1ns/10ps
`default_nettype none
module wrx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    import wrx_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage words.
    logic [AW-1:0]    wr_ptr_ff;        // Next slot to fill.
    logic [AW-1:0]    rd_ptr_ff;        // Oldest slot.
    logic [AW:0]      count_ff;         // Words held.
    logic             in_rdy_ff;        // Registered not-full flag.
    logic             push;             // Write accepted this cycle.
    logic             pop;              // Read accepted this cycle.
    logic [AW:0]      nxt_count;        // Occupancy after this cycle.

    assign push          = in_valid_in && in_rdy_ff;
    assign pop           = out_ready_in && (count_ff != '0);
    assign nxt_count     = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_out  = mem_ff[rd_ptr_ff];
    assign out_valid_out = count_ff != '0;
    assign in_ready_out  = in_rdy_ff;

    // Storage writes need no reset; unread slots are never shown as valid.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // Pointers, count and the ready flag; ready is registered so that a full
    // buffer stalls the source without a combinational path back to it.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            in_rdy_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff  <= nxt_count;
            in_rdy_ff <= nxt_count < (AW+1)'(DEPTH);
        end
    end

    // Occupancy never passes the depth.
    property p_fifo_bound;
        @(posedge clk_in) disable iff (rst_in) count_ff <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");
endmodule
`default_nettype wire

// *** core/wrx_signal_tx.sv ***
// Receiver packet signalling: phase sequencing, framing and bi-phase load modulation.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Bi-phase modulate bits at 2 kHz.
// - One: mid-bit transition; zero: none.
// - Every byte goes out as 11 bits.
// - Start, eight data, parity, stop.
// - Send by switching the coil load.
// - Phases: select, ping, configure, power.
// - Wake only above rectified wake threshold.
// - No packets while still in selection.
// - Ping sends signal strength or end power.
// - Signal strength sent moves to configuration.
// - End power packets keep ping phase.
// - Identify, configure, extras, seven optional.
// - Configuration sent moves to power transfer.
// - Power phase sends control packets freely.
module wrx_signal_tx #(
    parameter int         BIT_CYCLES    = wrx_pkg::BIT_CYCLES,
    parameter int         PREAMBLE_BITS = wrx_pkg::PREAMBLE_BITS,
    parameter int         FIFO_DEPTH    = wrx_pkg::FIFO_DEPTH,
    parameter logic [7:0] HDR_SS        = wrx_pkg::HDR_SIG_STRENGTH,
    parameter logic [7:0] HDR_EPT       = wrx_pkg::HDR_END_POWER,
    parameter logic [7:0] HDR_ID        = wrx_pkg::HDR_IDENT,
    parameter logic [7:0] HDR_XID       = wrx_pkg::HDR_EXT_IDENT,
    parameter logic [7:0] HDR_CFG       = wrx_pkg::HDR_CONFIG
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      rectified_wake_threshold_in,
    input  wire logic                      pkt_valid_in,
    input  wire logic [7:0]                pkt_hdr_in,
    input  wire logic [wrx_pkg::LEN_W-1:0] pkt_len_in,
    output logic                           pkt_ready_out,
    output logic                           pkt_reject_out,
    input  wire logic [7:0]                msg_data_in,
    input  wire logic                      msg_valid_in,
    output logic                           msg_ready_out,
    output logic                           load_mod_out,
    output logic [1:0]                     phase_out,
    output logic                           busy_out
);
    import wrx_pkg::*;

    localparam int CW = $clog2(BIT_CYCLES);

    // Builds one serial character, least significant bit sent first:
    // a zero start bit, data LSB first, odd parity, then a one stop bit.
    function automatic logic [CHAR_BITS-1:0] make_char(input logic [7:0] b);
        return {1'b1, ~(^b), b, 1'b0};
    endfunction

    // Decides whether a header may be sent in the given phase.
    function automatic logic hdr_allowed(input wrx_phase_type ph,
                                         input logic [7:0]    h,
                                         input logic [2:0]    opt);
        logic ok;
        ok = 1'b0;
        case (ph)
            PH_SELECT: ok = 1'b0;
            PH_PING:   ok = (h == HDR_SS) || (h == HDR_EPT);
            PH_IDCFG:  ok = (h == HDR_ID) || (h == HDR_CFG) || (h == HDR_XID)
                            || (opt < 3'(MAX_OPT_CFG));
            PH_POWER:  ok = 1'b1;
            default:   ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic                 wake_meta_ff;     // First synchroniser stage.
    logic                 wake_sync_ff;     // Synchronised wake level.
    wrx_phase_type        phase_ff;         // Current link phase.
    wrx_tx_type           tx_ff;            // Frame sequencer state.
    logic [CW-1:0]        cyc_ff;           // Cycle within the current bit.
    logic [4:0]           bits_ff;          // Bits left in the current unit.
    logic [CHAR_BITS-1:0] sh_ff;            // Outgoing bits, LSB next.
    logic [LEN_W-1:0]     msg_left_ff;      // Message bytes still to come.
    logic [7:0]           csum_ff;          // Running checksum.
    logic                 csum_sent_ff;     // Checksum character loaded.
    logic [7:0]           hdr_ff;           // Header of the packet in flight.
    logic [2:0]           opt_cnt_ff;       // Optional packets in this phase.
    logic                 mod_ff;           // Load switch drive.
    logic                 pkt_rdy_ff;       // Ready for a new packet.
    logic                 reject_ff;        // One-cycle refusal pulse.
    logic                 busy_ff;          // Sequencer not idle.
    logic [7:0]           f_data;           // Buffered message byte.
    logic                 f_valid;          // Buffer holds a byte.
    logic                 f_pop;            // Sequencer takes a byte.
    logic                 f_in_rdy;         // Buffer can accept a byte.
    logic                 take;             // Packet request taken.
    logic                 ok;               // Taken header is legal now.
    logic                 sending;          // A bit is on the air.
    logic                 bit_end;          // Last cycle of a bit.
    logic                 unit_end;         // Last cycle of a unit.
    logic                 pkt_done;         // Last cycle of a packet.

    assign take     = pkt_valid_in && pkt_rdy_ff && (phase_ff != PH_SELECT);
    assign ok       = hdr_allowed(phase_ff, pkt_hdr_in, opt_cnt_ff);
    assign sending  = (tx_ff == TX_PRE) || (tx_ff == TX_CHAR);
    assign bit_end  = sending && (cyc_ff == CW'(BIT_CYCLES - 1));
    assign unit_end = bit_end && (bits_ff == 5'h01);
    assign pkt_done = unit_end && (tx_ff == TX_CHAR) && (msg_left_ff == '0) && csum_sent_ff;
    assign f_pop    = f_valid && ((tx_ff == TX_FETCH) ||
                                  ((tx_ff == TX_DROP) && (msg_left_ff != '0)));

    assign pkt_ready_out  = pkt_rdy_ff;
    assign pkt_reject_out = reject_ff;
    assign msg_ready_out  = f_in_rdy;
    assign load_mod_out   = mod_ff;
    assign phase_out      = phase_ff;
    assign busy_out       = busy_ff;

    // Message bytes wait here; a full buffer drops msg_ready_out.
    wrx_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_data_in    (msg_data_in),
        .in_valid_in   (msg_valid_in),
        .in_ready_out  (f_in_rdy),
        .out_data_out  (f_data),
        .out_valid_out (f_valid),
        .out_ready_in  (f_pop)
    );

    // The wake comparator is analogue and asynchronous, so it is synchronised.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
        end else begin
            wake_meta_ff <= rectified_wake_threshold_in;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    // Phase sequencing. Losing the wake level returns to selection, but only
    // between packets so that a character is never cut short.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_ff   <= PH_SELECT;
            opt_cnt_ff <= RST_OPT_CNT;
        end else if (!wake_sync_ff && (tx_ff == TX_IDLE) && !take) begin
            phase_ff   <= PH_SELECT;
            opt_cnt_ff <= RST_OPT_CNT;
        end else begin
            case (phase_ff)
                PH_SELECT: begin
                    // Digital side wakes only above the rectified threshold.
                    if (wake_sync_ff) begin
                        phase_ff <= PH_PING;
                    end
                end
                PH_PING: begin
                    // End power packets leave the phase unchanged.
                    if (pkt_done && (hdr_ff == HDR_SS)) begin
                        phase_ff   <= PH_IDCFG;
                        opt_cnt_ff <= RST_OPT_CNT;
                    end
                end
                PH_IDCFG: begin
                    // Optional packets are counted as they are taken.
                    if (take && ok && (pkt_hdr_in != HDR_ID) &&
                        (pkt_hdr_in != HDR_CFG) && (pkt_hdr_in != HDR_XID)) begin
                        opt_cnt_ff <= opt_cnt_ff + 3'h1;
                    end
                    if (pkt_done && (hdr_ff == HDR_CFG)) begin
                        phase_ff <= PH_POWER;
                    end
                end
                PH_POWER: begin
                    // Any control or proprietary packet is sent here.
                    phase_ff <= PH_POWER;
                end
                default: begin
                    phase_ff <= PH_SELECT;
                end
            endcase
        end
    end

    // Frame sequencer: preamble, header, message bytes, then checksum.
    // A refused packet still has its message bytes drained and discarded.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_ff        <= TX_IDLE;
            sh_ff        <= '0;
            bits_ff      <= '0;
            msg_left_ff  <= '0;
            csum_ff      <= RST_BYTE;
            csum_sent_ff <= 1'b0;
            hdr_ff       <= RST_BYTE;
        end else begin
            case (tx_ff)
                TX_IDLE: begin
                    if (take && ok) begin
                        tx_ff        <= TX_PRE;
                        sh_ff        <= '1;
                        bits_ff      <= 5'(PREAMBLE_BITS);
                        hdr_ff       <= pkt_hdr_in;
                        msg_left_ff  <= pkt_len_in;
                        csum_ff      <= pkt_hdr_in;
                        csum_sent_ff <= 1'b0;
                    end else if (take && (pkt_len_in != '0)) begin
                        tx_ff       <= TX_DROP;
                        msg_left_ff <= pkt_len_in;
                    end
                end
                TX_PRE: begin
                    if (unit_end) begin
                        tx_ff   <= TX_CHAR;
                        sh_ff   <= make_char(hdr_ff);
                        bits_ff <= 5'(CHAR_BITS);
                    end else if (bit_end) begin
                        bits_ff <= bits_ff - 5'h01;
                    end
                end
                TX_CHAR: begin
                    if (unit_end) begin
                        if (msg_left_ff != '0) begin
                            tx_ff <= TX_FETCH;
                        end else if (!csum_sent_ff) begin
                            sh_ff        <= make_char(csum_ff);
                            bits_ff      <= 5'(CHAR_BITS);
                            csum_sent_ff <= 1'b1;
                        end else begin
                            tx_ff <= TX_IDLE;
                        end
                    end else if (bit_end) begin
                        sh_ff   <= {1'b0, sh_ff[CHAR_BITS-1:1]};
                        bits_ff <= bits_ff - 5'h01;
                    end
                end
                TX_FETCH: begin
                    // Stalls here while the source has not supplied the byte.
                    if (f_valid) begin
                        tx_ff       <= TX_CHAR;
                        sh_ff       <= make_char(f_data);
                        bits_ff     <= 5'(CHAR_BITS);
                        msg_left_ff <= msg_left_ff - LEN_W'(1);
                        csum_ff     <= csum_ff ^ f_data;
                    end
                end
                TX_DROP: begin
                    if (f_pop) begin
                        msg_left_ff <= msg_left_ff - LEN_W'(1);
                        if (msg_left_ff == LEN_W'(1)) begin
                            tx_ff <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_ff <= TX_IDLE;
                end
            endcase
        end
    end

    // Bit timer: one bit lasts one period of the 2 kHz bit clock.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cyc_ff <= '0;
        end else if (sending && !bit_end) begin
            cyc_ff <= cyc_ff + CW'(1);
        end else begin
            cyc_ff <= '0;
        end
    end

    // Load switch: every bit starts with a transition, and a one adds a
    // second one halfway. The line rests low between packets, which after a
    // packet with an odd message length costs one trailing edge that the far end decodes as one extra zero bit.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mod_ff <= 1'b0;
        end else if (sending && (cyc_ff == '0)) begin
            mod_ff <= ~mod_ff;
        end else if (sending && (cyc_ff == CW'(BIT_CYCLES / 2)) && sh_ff[0]) begin
            mod_ff <= ~mod_ff;
        end else if (tx_ff == TX_IDLE) begin
            mod_ff <= 1'b0;
        end
    end

    // Request handshake and status; ready falls the cycle after a take.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pkt_rdy_ff <= 1'b0;
            reject_ff  <= 1'b0;
            busy_ff    <= 1'b0;
        end else begin
            pkt_rdy_ff <= (tx_ff == TX_IDLE) && !take && wake_sync_ff &&
                          (phase_ff != PH_SELECT);
            reject_ff  <= take && !ok;
            busy_ff    <= tx_ff != TX_IDLE;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_char_start;
        (tx_ff == TX_CHAR) && (bits_ff == 5'(CHAR_BITS)) && (cyc_ff == '0);
    endsequence

    property p_bit_edge;
        (sending && (cyc_ff == '0)) |=> (mod_ff != $past(mod_ff));
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("no bit edge");

    property p_half_edge;
        (sending && (cyc_ff == CW'(BIT_CYCLES / 2))) |=> (mod_ff != $past(mod_ff)) == $past(sh_ff[0]);
    endproperty
    a_half_edge: assert property (p_half_edge) else $error("bad mid-bit");

    property p_char_frame;
        s_char_start |-> !sh_ff[0] && sh_ff[CHAR_BITS-1] && (sh_ff[9] == ~(^sh_ff[8:1]));
    endproperty
    a_char_frame: assert property (p_char_frame) else $error("bad char frame");

    property p_no_send_select;
        (tx_ff != TX_IDLE && tx_ff != TX_DROP) |-> phase_ff != PH_SELECT;
    endproperty
    a_no_send_select: assert property (p_no_send_select) else $error("sent in selection");

    property p_wake_gate;
        (phase_ff == PH_SELECT) ##1 (phase_ff == PH_PING) |-> $past(wake_sync_ff);
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("woke without wake");

    property p_phase_order;
        (phase_ff != $past(phase_ff)) |->
            (phase_ff == PH_SELECT) || (2'(phase_ff) == 2'($past(phase_ff)) + 2'h1);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase skipped");

    property p_ss_advance;
        (pkt_done && (phase_ff == PH_PING) && (hdr_ff == HDR_SS)) |=> phase_ff == PH_IDCFG;
    endproperty
    a_ss_advance: assert property (p_ss_advance) else $error("ping did not advance");

    property p_ept_stay;
        (pkt_done && (phase_ff == PH_PING) && (hdr_ff == HDR_EPT)) |=> phase_ff == PH_PING;
    endproperty
    a_ept_stay: assert property (p_ept_stay) else $error("ping left on end power");

    property p_ping_cause;
        (phase_ff == PH_PING) ##1 (phase_ff == PH_IDCFG) |-> $past(hdr_ff) == HDR_SS;
    endproperty
    a_ping_cause: assert property (p_ping_cause) else $error("left ping wrongly");

    property p_cfg_advance;
        (pkt_done && (phase_ff == PH_IDCFG) && (hdr_ff == HDR_CFG)) |=> phase_ff == PH_POWER;
    endproperty
    a_cfg_advance: assert property (p_cfg_advance) else $error("config did not advance");

    // The eighth optional packet in the configuration phase must be refused.
    property p_opt_limit;
        (take && (phase_ff == PH_IDCFG) && (opt_cnt_ff == 3'(MAX_OPT_CFG)) &&
         (pkt_hdr_in != HDR_ID) && (pkt_hdr_in != HDR_CFG) && (pkt_hdr_in != HDR_XID)) |=> reject_ff;
    endproperty
    a_opt_limit: assert property (p_opt_limit) else $error("too many optional");

    property p_csum;
        $rose(csum_sent_ff) |-> sh_ff[8:1] == $past(csum_ff);
    endproperty
    a_csum: assert property (p_csum) else $error("bad checksum char");
endmodule
`default_nettype wire

// *** bench/wrx_base_model.sv ***
// Base station model that recovers bits from the receiver's load modulation.
`timescale 1ns/10ps
`default_nettype none
module wrx_base_model #(
    parameter int BITC = 20
) (
    input  wire logic clk_in,
    input  wire logic mod_in
);
    logic prev_ff = 1'b0;  // Line level one cycle back.
    logic lvl_ff  = 1'b0;  // Level at the last boundary or sample point.
    logic on_ff   = 1'b0;  // High while a frame is being received.
    int   cnt_ff  = 0;     // Cycles since the last bit boundary.
    logic bits[$];         // Recovered bits, cleared by the bench per packet.
    // A one carries a mid-bit edge, so the level three quarters in is compared with
    // the level at the boundary; a missing boundary edge closes the frame.
    always @(posedge clk_in) begin
        prev_ff <= mod_in;
        cnt_ff <= cnt_ff + 1;
        if (!on_ff) begin
            cnt_ff <= 1;
            lvl_ff <= mod_in;
            on_ff <= (mod_in !== prev_ff);
        end else if (cnt_ff == BITC * 3 / 4) begin
            bits.push_back(mod_in !== lvl_ff);
            lvl_ff <= mod_in;
        end else if (cnt_ff == BITC) begin
            on_ff <= (mod_in !== lvl_ff);
            lvl_ff <= mod_in;
            cnt_ff <= 1;
        end
    end
endmodule
`default_nettype wire

// *** bench/wrx_signal_tx_test.sv ***
// Self-checking bench for the receiver packet signalling block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module wrx_signal_tx_test;
    import wrx_pkg::*;
    localparam int BC = 20;  // Short bit period keeps the run brief.
    logic clk_in = 1'b0, rst_in = 1'b1, wake = 1'b0, pv = 1'b0, mv = 1'b0;
    logic [7:0] ph = 8'h00, md = 8'h00;
    logic [4:0] pl = 5'h00;
    logic pkt_ready_out, pkt_reject_out, msg_ready_out, load_mod_out, busy_out;
    logic [1:0] phase_out;
    int   checked = 0, mismatches = 0;
    logic [7:0] sent[$];  // Bytes pushed and not yet paired with a packet.
    logic exp[$];         // Expected bit stream of one packet.
    wrx_signal_tx #(.BIT_CYCLES(BC)) wrx_signal_tx_inst (.clk_in(clk_in), .rst_in(rst_in),
        .rectified_wake_threshold_in(wake), .pkt_valid_in(pv), .pkt_hdr_in(ph),
        .pkt_len_in(pl), .pkt_ready_out(pkt_ready_out), .pkt_reject_out(pkt_reject_out),
        .msg_data_in(md), .msg_valid_in(mv), .msg_ready_out(msg_ready_out),
        .load_mod_out(load_mod_out), .phase_out(phase_out), .busy_out(busy_out));
    wrx_base_model #(.BITC(BC)) wrx_base_model_inst (.clk_in(clk_in), .mod_in(load_mod_out));
    initial forever #5 clk_in = ~clk_in;
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded wait on a ready flag; running out counts as a mismatch.
    task automatic waitfor(input logic msg);
        int n;
        for (n = 0; n < 5000 && (msg ? msg_ready_out : pkt_ready_out) !== 1'b1; n++)
            @(negedge clk_in);
        if (n == 5000) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic push(input logic [7:0] b);
        waitfor(1'b1);
        mv = 1'b1;
        md = b;
        sent.push_back(b);
        @(negedge clk_in);
        mv = 1'b0;
        // Let one edge pass with valid low so back-to-back calls never retoggle it.
        @(negedge clk_in);
    endtask
    // One character: start, data low bit first, odd parity, stop.
    task automatic addc(input logic [7:0] d);
        exp.push_back(1'b0);
        for (int i = 0; i < 8; i++) exp.push_back(d[i]);
        exp.push_back(~^d);
        exp.push_back(1'b1);
    endtask
    // Requests a packet, then checks the refusal flag and the decoded frame.
    task automatic send(input logic [7:0] hdr, input logic [4:0] len, input logic rej);
        logic r;
        logic [7:0] x;
        waitfor(1'b0);
        wrx_base_model_inst.bits.delete();
        pv = 1'b1;
        ph = hdr;
        pl = len;
        @(negedge clk_in);
        pv = 1'b0;
        r = pkt_reject_out;
        @(negedge clk_in);
        r = r | pkt_reject_out;
        `CHK("reject", rej, r)
        `CHK("busy", !rej || (len != 5'h00), busy_out)
        waitfor(1'b0);
        repeat (3 * BC) @(negedge clk_in);
        exp.delete();
        repeat (PREAMBLE_BITS) exp.push_back(1'b1);
        x = hdr;
        addc(hdr);
        for (int i = 0; i < len; i++) begin
            x = x ^ sent[0];
            addc(sent.pop_front());
        end
        addc(x);
        if (rej) exp.delete();
        // A refused packet must leave the load untouched.
        r = rej ? wrx_base_model_inst.bits.size() == 0
                : wrx_base_model_inst.bits.size() >= exp.size();
        `CHK("nbits", 1'b1, r)
        foreach (exp[i])
            if (i < wrx_base_model_inst.bits.size())
                `CHK("bit", exp[i], wrx_base_model_inst.bits[i])
    endtask
    // Asleep: a held request is never taken and the load stays still.
    task t_select;
        pv = 1'b1;
        repeat (40) begin
            @(negedge clk_in);
            `CHK("ready_asleep", 1'b0, pkt_ready_out | load_mod_out)
        end
        pv = 1'b0;
        `CHK("phase_sel", 2'h0, phase_out)
        $display("t_select done");
    endtask
    task t_ping;
        // The station keeps its power on until t_power drops it, so wake stays high till then.
        wake = 1'b1;
        send(HDR_IDENT, 5'h00, 1'b1);
        send(HDR_END_POWER, 5'h00, 1'b0);
        `CHK("phase_ept", 2'h1, phase_out)
        push(8'ha5);
        send(HDR_SIG_STRENGTH, 5'h01, 1'b0);
        `CHK("phase_ss", 2'h2, phase_out)
        $display("t_ping done");
    endtask
    task t_idcfg;
        send(HDR_IDENT, 5'h00, 1'b0);
        send(HDR_EXT_IDENT, 5'h00, 1'b0);
        send(8'h20, 5'h00, 1'b0);
        for (int i = 0; i < 6; i++) send(8'h20, 5'h00, 1'b0);
        // The eighth optional packet is refused and its byte is dropped.
        push(8'h5a);
        send(8'h20, 5'h01, 1'b1);
        `CHK("phase_id", 2'h2, phase_out)
        send(HDR_CONFIG, 5'h00, 1'b0);
        `CHK("phase_cfg", 2'h3, phase_out)
        $display("t_idcfg done");
    endtask
    // Fill the buffer until it refuses, then drain it in one long packet.
    task t_power;
        for (int i = 0; i < 8; i++) push(8'h10 + 8'(i * 37));
        @(negedge clk_in);
        `CHK("fifo_full", 1'b0, msg_ready_out)
        send(8'h03, 5'h08, 1'b0);
        `CHK("fifo_free", 1'b1, msg_ready_out)
        wake = 1'b0;
        for (int n = 0; n < 20 && phase_out !== 2'h0; n++) @(negedge clk_in);
        `CHK("phase_off", 2'h0, phase_out)
        $display("t_power done");
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        `CHK("rst_outs", 4'h0, {pkt_ready_out, load_mod_out, busy_out, pkt_reject_out})
        t_select();
        t_ping();
        t_idcfg();
        t_power();
        report_and_stop();
    end
endmodule
`default_nettype wire
